// ===== inc/dio_glue_pkg.sv
// Constants shared by the digital I/O board glue and its group units.
// Assumes a 125 MHz system clock and a host I/O bus sampled on that clock.
`default_nettype none

package dio_glue_pkg;

   // ****************************************************************
   // Host window layout
   // ****************************************************************
   localparam int ADDR_W = 10;
   localparam int OFFS_W = 4;
   localparam logic [3:0] OFFS_G0 = 4'h0;      // Group 0 ports A, B, C, control
   localparam logic [3:0] OFFS_G1 = 4'h4;      // Group 1 ports A, B, C, control
   localparam logic [3:0] OFFS_INT_EN = 4'hB;  // Write enables, read disables
   localparam logic [3:0] OFFS_MAP = 4'hD;     // Write maps counters in, read maps out
   localparam logic [3:0] OFFS_BUF = 4'hE;     // Soft buffer enable, bit 0
   localparam logic [3:0] OFFS_CLR = 4'hF;     // Write clears pending request
   localparam logic [1:0] SUB_A = 2'h0;
   localparam logic [1:0] SUB_B = 2'h1;
   localparam logic [1:0] SUB_C = 2'h2;
   localparam logic [1:0] SUB_CTRL = 2'h3;
   localparam logic [7:0] READ_IDLE = 8'hFF;   // Unmapped offsets read back

   // ****************************************************************
   // Control byte fields of a parallel_interface_unit
   // ****************************************************************
   localparam int CTL_MODE_SET = 7;
   localparam int CTL_A_IN = 4;
   localparam int CTL_CU_IN = 3;
   localparam int CTL_B_IN = 1;
   localparam int CTL_CL_IN = 0;
   localparam int PIN_C3 = 19;                 // group_edge_interrupt_bit
   localparam int PIN_C7 = 23;
   localparam logic [7:0] CTL_RESET = 8'h9B;   // All ports input

   // ****************************************************************
   // Counter timer and interrupt routing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int TIMER_PERIOD_NS = 1000;      // 1 MHz counter clock
   localparam int TIMER_DIV = TIMER_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TIMER_HIGH = TIMER_DIV / 2;
   localparam int CNT_W = 16;
   localparam int NUM_CNT = 3;
   localparam int NUM_IRQ = 8;                 // Levels 3..7, 10..12

   typedef enum logic [1:0] {INT_NEVER, INT_ALWAYS, INT_GATED} int_mode_t;

endpackage : dio_glue_pkg

`default_nettype wire

// ===== inc/group_link_if.sv
// Carries one 24-line group between the glue top and its group unit.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface group_link_if;
   logic wr;              // One-cycle write to this group
   logic [1:0] sub;       // Port A, B, C or control
   logic [7:0] wdata;
   logic [23:0] pin_in;   // Raw field pins
   logic [23:0] pin_val;  // Debounced pin levels
   logic [23:0] port_out; // Output latches
   logic [23:0] drive;    // 1 where the line is an output
   logic [7:0] ctrl;
   logic c3_rise;         // One-cycle rising edge of port C bit 3
   modport unit (input wr, sub, wdata, pin_in,
                 output pin_val, port_out, drive, ctrl, c3_rise);
   modport glue (output wr, sub, wdata, pin_in,
                 input pin_val, port_out, drive, ctrl, c3_rise);
endinterface : group_link_if

`default_nettype wire

// ===== rtl/group_unit.sv
// One 24-line group: output latches, direction snooped from the control byte,
// pin synchronisers and the rising-edge detector on port C bit 3.
// Assumes writes arrive as one-cycle pulses from the glue top.
`timescale 1ns/100ps
`default_nettype none

module group_unit (
   input wire logic clk,
   input wire logic nrst,
   group_link_if.unit lnk
);

   logic [23:0] s1;
   logic [23:0] s2;
   logic [23:0] s3;
   logic [23:0] pin_val;
   logic [7:0] ctrl;
   logic [23:0] port_out;
   logic c3_rise;
   logic ctl_wr;
   logic mode_wr;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // A level counts only once the second and third stages agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1 <= 24'hFFFFFF;  // Pins idle high on their pull-ups, so no false edge
         s2 <= 24'hFFFFFF;
         s3 <= 24'hFFFFFF;
         pin_val <= 24'hFFFFFF;
      end else begin
         s1 <= lnk.pin_in;
         s2 <= s1;
         s3 <= s2;
         pin_val <= (s2 & s3) | (pin_val & (s2 ^ s3));
      end
   end

   // Rising edge of the group interrupt pin, one cycle wide
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         c3_rise <= 1'b0;
      end else begin
         c3_rise <= s2[dio_glue_pkg::PIN_C3] & s3[dio_glue_pkg::PIN_C3]
                    & ~pin_val[dio_glue_pkg::PIN_C3];  // see (R06)
      end
   end

   // ****************************************************************
   // Control byte snoop and output latches
   // ****************************************************************
   assign ctl_wr = lnk.wr && (lnk.sub == dio_glue_pkg::SUB_CTRL);
   assign mode_wr = ctl_wr && lnk.wdata[dio_glue_pkg::CTL_MODE_SET];

   // Mode set clears latches so a port turning output starts low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= dio_glue_pkg::CTL_RESET;  // see (R18)
         port_out <= 24'h000000;
      end else if (mode_wr) begin
         ctrl <= lnk.wdata;  // see (R10)
         port_out <= 24'h000000;
      end else if (ctl_wr) begin
         port_out[16 + lnk.wdata[3:1]] <= lnk.wdata[0];
      end else if (lnk.wr && lnk.sub != dio_glue_pkg::SUB_CTRL) begin
         port_out[lnk.sub * 8 +: 8] <= lnk.wdata;  // see (R04)
      end
   end

   // Direction per port, port C split in nibbles
   assign lnk.drive = {{4{~ctrl[dio_glue_pkg::CTL_CU_IN]}},
                       {4{~ctrl[dio_glue_pkg::CTL_CL_IN]}},
                       {8{~ctrl[dio_glue_pkg::CTL_B_IN]}},
                       {8{~ctrl[dio_glue_pkg::CTL_A_IN]}}};  // see (R05)
   assign lnk.ctrl = ctrl;
   assign lnk.port_out = port_out;
   assign lnk.pin_val = pin_val;
   assign lnk.c3_rise = c3_rise;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_mode_dir;
      @(posedge clk) disable iff (!nrst)
      mode_wr |=> (lnk.drive[0] == ~$past(lnk.wdata[dio_glue_pkg::CTL_A_IN]))
                  && (lnk.drive[20] == ~$past(lnk.wdata[dio_glue_pkg::CTL_CU_IN]));
   endproperty
   a_mode_dir: assert property (p_mode_dir) else $error("direction not taken from control byte"); // see (R10)

   property p_latch_hold;
      @(posedge clk) disable iff (!nrst)
      (lnk.wr && lnk.sub == dio_glue_pkg::SUB_A) ##1 !lnk.wr [*3]
         |-> port_out[7:0] == $past(lnk.wdata, 3);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("port A latch lost"); // see (R04)

   property p_c3_edge;
      @(posedge clk) disable iff (!nrst)
      c3_rise |-> pin_val[dio_glue_pkg::PIN_C3] && !$past(pin_val[dio_glue_pkg::PIN_C3]);
   endproperty
   a_c3_edge: assert property (p_c3_edge) else $error("edge pulse without low to high"); // see (R06)

   c_c3_edge: cover property (@(posedge clk) disable iff (!nrst) c3_rise);

endmodule : group_unit

`default_nettype wire

// ===== rtl/dio_glue.sv
// Glue of a 48-line buffered digital I/O board on an 8-bit host I/O bus.
// Assumes host strobes, address and data come from another clock domain.
// What this block does
// (R01) Answer sixteen byte addresses from the base
// (R02) Base on 16-byte steps, 000 to 3F0
// (R03) Two groups of ports A, B, C
// (R04) Ports input or latched output
// (R05) Port C nibbles set independently
// (R06) Rising port C bit 3 requests interrupt
// (R07) Both group requests ORed to one line
// (R08) Group source always, never, or bit-7-low gated
// (R09) Request routed to one of eight levels
// (R10) Buffer direction follows snooped control byte
// (R11) Buffers always driven or software tristated
// (R12) Counters clocked at 1 MHz, falling edge
// (R13) 16-bit counters, two cascade to 32
// (R14) Write B enables, read B disables interrupts
// (R15) Further requests wait for write to F
// (R16) Write D maps counters, read D unmaps
// (R17) Soft option takes enable from register bit
// (R18) Reset: inputs, interrupts cleared and disabled
`timescale 1ns/100ps
`default_nettype none

module dio_glue (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [9:0] bus_addr,
   input wire logic bus_aen,
   input wire logic bus_iow_n,
   input wire logic bus_ior_n,
   input wire logic [7:0] bus_data_in,
   output logic [7:0] bus_data_out,
   output logic bus_data_oe,
   input wire logic [5:0] base_sel,
   input wire logic [2:0] irq_sel,
   input wire dio_glue_pkg::int_mode_t int_mode0,
   input wire dio_glue_pkg::int_mode_t int_mode1,
   input wire logic always_buffer_drive_option,
   input wire logic cascade_en,
   input wire logic [47:0] pin_in,
   output logic [47:0] pin_out,
   output logic [47:0] pin_oe,
   output logic [7:0] irq_line,
   output logic timer_clk,
   output logic counter_mapped,
   output logic [2:0] count_zero
);

   // ****************************************************************
   // Host bus synchronisers
   // ****************************************************************
   // Address, data, enable and both strobes: 10 + 8 + 3 bits
   localparam int SYNC_W = 21;
   logic [SYNC_W-1:0] h1;
   logic [SYNC_W-1:0] h2;
   logic [SYNC_W-1:0] h3;
   logic iow_stable;
   logic ior_stable;
   logic wr_ev;
   logic rd_ev;
   logic hit;
   logic [3:0] offs;
   logic [7:0] wdata;

   // A strobe edge counts once the second and third stages agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         h1 <= {SYNC_W{1'b1}};
         h2 <= {SYNC_W{1'b1}};
         h3 <= {SYNC_W{1'b1}};
         iow_stable <= 1'b1;
         ior_stable <= 1'b1;
      end else begin
         h1 <= {bus_addr, bus_data_in, bus_aen, bus_iow_n, bus_ior_n};
         h2 <= h1;
         h3 <= h2;
         iow_stable <= (h2[1] == h3[1]) ? h3[1] : iow_stable;
         ior_stable <= (h2[0] == h3[0]) ? h3[0] : ior_stable;
      end
   end

   // Window decode compares the six upper address bits to the base
   assign hit = !h3[2] && (h3[20:15] == base_sel);  // see (R02)
   assign offs = h3[14:11];  // see (R01)
   assign wdata = h3[10:3];
   assign wr_ev = hit && !h2[1] && !h3[1] && iow_stable;
   assign rd_ev = hit && !h2[0] && !h3[0] && ior_stable;

   // ****************************************************************
   // Groups
   // ****************************************************************
   group_link_if link[2] ();
   logic [1:0] c3_rise;
   logic [1:0] c7_low;
   logic [47:0] drive_all;
   logic [47:0] latch_all;
   logic [47:0] pin_val_all;

   // Address test used for both group decode and read selection
   function automatic logic in_group(input logic [3:0] o, input logic [3:0] base);
      in_group = (o[3:2] == base[3:2]);
   endfunction : in_group

   generate
      for (genvar g = 0; g < 2; g++) begin : g_grp
         localparam logic [3:0] GBASE = (g == 0) ? dio_glue_pkg::OFFS_G0
                                                 : dio_glue_pkg::OFFS_G1;
         // Group 0 steps aside while the counters are mapped in
         assign link[g].wr = wr_ev && in_group(offs, GBASE)
                             && !(g == 0 && counter_mapped);  // see (R16)
         assign link[g].sub = offs[1:0];
         assign link[g].wdata = wdata;
         assign link[g].pin_in = pin_in[g*24 +: 24];
         assign c3_rise[g] = link[g].c3_rise;
         assign c7_low[g] = ~link[g].pin_val[dio_glue_pkg::PIN_C7];
         assign drive_all[g*24 +: 24] = link[g].drive;
         assign latch_all[g*24 +: 24] = link[g].port_out;
         assign pin_val_all[g*24 +: 24] = link[g].pin_val;
         group_unit u_grp (.clk(clk), .nrst(nrst), .lnk(link[g]));  // see (R03)
      end
   endgenerate

   // ****************************************************************
   // Line buffers
   // ****************************************************************
   logic soft_buf_en;
   logic buf_drive;

   assign buf_drive = always_buffer_drive_option | soft_buf_en;  // see (R11)

   // Soft enable register; disabled until software sets it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         soft_buf_en <= 1'b0;
      end else if (wr_ev && offs == dio_glue_pkg::OFFS_BUF) begin
         soft_buf_en <= wdata[0];  // see (R17)
      end
   end

   // Output enables follow the snooped directions, gated by the option or the soft enable
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_oe <= 48'h000000000000;  // see (R18)
         pin_out <= 48'h000000000000;
      end else begin
         pin_oe <= drive_all & {48{buf_drive}};  // see (R10)
         pin_out <= latch_all;
      end
   end

   // ****************************************************************
   // Interrupt logic
   // ****************************************************************
   logic int_en;
   logic int_pend;
   logic raise;
   logic clr;
   logic [1:0] src;

   // Per-group source gating by the configured option
   assign src[0] = c3_rise[0] && (int_mode0 == dio_glue_pkg::INT_ALWAYS
                   || (int_mode0 == dio_glue_pkg::INT_GATED && c7_low[0]));  // see (R08)
   assign src[1] = c3_rise[1] && (int_mode1 == dio_glue_pkg::INT_ALWAYS
                   || (int_mode1 == dio_glue_pkg::INT_GATED && c7_low[1]));  // see (R08)
   assign raise = int_en && (src[0] | src[1]);  // see (R07)
   assign clr = wr_ev && offs == dio_glue_pkg::OFFS_CLR;

   // Edge landing with the clear is kept: set wins over clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         int_en <= 1'b0;
         int_pend <= 1'b0;  // see (R18)
      end else begin
         if (wr_ev && offs == dio_glue_pkg::OFFS_INT_EN) begin
            int_en <= 1'b1;  // see (R14)
         end else if (rd_ev && offs == dio_glue_pkg::OFFS_INT_EN) begin
            int_en <= 1'b0;  // see (R14)
         end
         int_pend <= raise | (int_pend & ~clr);  // see (R15)
      end
   end

   // One-hot routing of the single request line
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_line <= 8'h00;
      end else begin
         irq_line <= int_pend ? (8'h01 << irq_sel) : 8'h00;  // see (R09)
      end
   end

   // ****************************************************************
   // Counter timer
   // ****************************************************************
   logic [6:0] div;
   logic tick;
   logic [dio_glue_pkg::CNT_W-1:0] cnt [dio_glue_pkg::NUM_CNT];
   logic [dio_glue_pkg::CNT_W-1:0] reload [dio_glue_pkg::NUM_CNT];
   logic [dio_glue_pkg::NUM_CNT-1:0] byte_hi;
   logic [dio_glue_pkg::NUM_CNT-1:0] dec;
   logic [dio_glue_pkg::NUM_CNT-1:0] wrap;

   // Divider makes the 1 MHz counter clock; a count happens on its fall
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div <= 7'h00;
         timer_clk <= 1'b0;
         counter_mapped <= 1'b0;
      end else begin
         div <= (div == 7'(dio_glue_pkg::TIMER_DIV - 1)) ? 7'h00 : div + 7'h01;
         timer_clk <= (div < 7'(dio_glue_pkg::TIMER_HIGH));  // see (R12)
         if (wr_ev && offs == dio_glue_pkg::OFFS_MAP) begin
            counter_mapped <= 1'b1;  // see (R16)
         end else if (rd_ev && offs == dio_glue_pkg::OFFS_MAP) begin
            counter_mapped <= 1'b0;  // see (R16)
         end
      end
   end

   assign tick = timer_clk && !(div < 7'(dio_glue_pkg::TIMER_HIGH));  // see (R12)

   generate
      for (genvar i = 0; i < dio_glue_pkg::NUM_CNT; i++) begin : g_cnt
         // Counter 1 may run from counter 0 wrapping, giving 32 bits
         if (i == 1) begin : g_casc
            assign dec[i] = cascade_en ? wrap[0] : tick;  // see (R13)
         end else begin : g_plain
            assign dec[i] = tick;
         end
         assign wrap[i] = dec[i] && (cnt[i] == '0);

         // Reload written low byte then high byte at offsets 0..2
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               cnt[i] <= '0;
               reload[i] <= '0;
               byte_hi[i] <= 1'b0;
               count_zero[i] <= 1'b0;
            end else begin
               count_zero[i] <= wrap[i];
               if (counter_mapped && wr_ev && offs == 4'(i)) begin
                  byte_hi[i] <= ~byte_hi[i];
                  reload[i][byte_hi[i]*8 +: 8] <= wdata;
               end
               if (wrap[i]) begin
                  cnt[i] <= reload[i];
               end else if (dec[i]) begin
                  cnt[i] <= cnt[i] - 16'h0001;  // see (R13)
               end
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] rd_mux;
   logic [47:0] rd_src;
   logic [2:0] gidx;

   // Inputs read the pins, outputs read their latch
   assign rd_src = (pin_val_all & ~drive_all) | (latch_all & drive_all);
   assign gidx = {offs[2], offs[1:0]};
   assign rd_mux = (counter_mapped && offs < 4'(dio_glue_pkg::NUM_CNT))
                   ? cnt[offs[1:0]][7:0]
                   : (in_group(offs, dio_glue_pkg::OFFS_G0)
                      || in_group(offs, dio_glue_pkg::OFFS_G1))
                   ? ((offs[1:0] == dio_glue_pkg::SUB_CTRL)
                      ? (offs[2] ? link[1].ctrl : link[0].ctrl)
                      : rd_src[(gidx[2] ? 24 : 0) + gidx[1:0] * 8 +: 8])
                   : dio_glue_pkg::READ_IDLE;

   // Data is driven from the read edge until the strobe rises again
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_data_out <= 8'h00;
         bus_data_oe <= 1'b0;
      end else if (rd_ev) begin
         bus_data_out <= rd_mux;
         bus_data_oe <= 1'b1;  // see (R01)
      end else if (ior_stable) begin
         bus_data_oe <= 1'b0;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_irq_onehot;
      @(posedge clk) disable iff (!nrst)
      (irq_line == 8'h00) || $onehot(irq_line);
   endproperty
   a_irq_onehot: assert property (p_irq_onehot) else $error("more than one level driven"); // see (R09)

   property p_raise_line;
      @(posedge clk) disable iff (!nrst)
      raise |=> ##1 irq_line != 8'h00;
   endproperty
   a_raise_line: assert property (p_raise_line) else $error("request not routed"); // see (R07)

   property p_clear;
      @(posedge clk) disable iff (!nrst)
      (clr && !raise) |=> !int_pend ##1 irq_line == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not drop request"); // see (R15)

   property p_en_toggle;
      @(posedge clk) disable iff (!nrst)
      (rd_ev && offs == dio_glue_pkg::OFFS_INT_EN) |=> !int_en;
   endproperty
   a_en_toggle: assert property (p_en_toggle) else $error("read did not disable"); // see (R14)

   property p_no_raise_disabled;
      @(posedge clk) disable iff (!nrst)
      (!int_en && !int_pend && !clr) |=> !int_pend;
   endproperty
   a_no_raise_disabled: assert property (p_no_raise_disabled) else $error("raised while disabled"); // see (R14)

   property p_map;
      @(posedge clk) disable iff (!nrst)
      (wr_ev && offs == dio_glue_pkg::OFFS_MAP) |=> counter_mapped && !link[0].wr;
   endproperty
   a_map: assert property (p_map) else $error("map write ignored"); // see (R16)

   property p_tristate;
      @(posedge clk) disable iff (!nrst)
      !buf_drive |=> pin_oe == 48'h000000000000;
   endproperty
   a_tristate: assert property (p_tristate) else $error("buffers driven while disabled"); // see (R11)

   property p_window;
      @(posedge clk) disable iff (!nrst)
      $rose(bus_data_oe) |-> $past(hit) && $past(h3[20:15]) == base_sel;
   endproperty
   a_window: assert property (p_window) else $error("answered outside window"); // see (R02)

   property p_timer_period;
      @(posedge clk) disable iff (!nrst)
      $fell(timer_clk) |-> ##125 $fell(timer_clk);
   endproperty
   a_timer_period: assert property (p_timer_period) else $error("counter clock not 1 MHz"); // see (R12)

   c_pend: cover property (@(posedge clk) disable iff (!nrst) $rose(int_pend));
   c_mapped: cover property (@(posedge clk) disable iff (!nrst) $rose(counter_mapped));
   c_cascade: cover property (@(posedge clk) disable iff (!nrst) cascade_en && wrap[1]);

endmodule : dio_glue

`default_nettype wire

// ===== tb/host_model.sv
// Host processor model driving I/O cycles into the board glue.
// Assumes the same clock as the glue and a fixed cycle timing.
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rdata_oe,
   output logic [9:0] addr,
   output logic aen,
   output logic iow_n,
   output logic ior_n,
   output logic [7:0] wdata
);
   // Idle bus at time zero
   initial begin
      addr = 10'h000;
      aen = 1'b0;
      iow_n = 1'b1;
      ior_n = 1'b1;
      wdata = 8'h00;
   end
   // One cycle; any write of B, D or F, or read of B or D, acts as a command
   task automatic io(input logic wr, input logic dma, input logic [9:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(negedge clk);
      addr = a;
      aen = dma;
      wdata = d;
      repeat (3) @(negedge clk);
      iow_n = ~wr;
      ior_n = wr;
      repeat (6) @(negedge clk);
      // An undriven data bus shows the inverse, so a missing enable is seen
      q = rdata_oe ? rdata : ~rdata;
      iow_n = 1'b1;
      ior_n = 1'b1;
      // Released data lines must not keep the old value
      wdata = ~d;
      aen = 1'b0;
      repeat (5) @(negedge clk);
   endtask : io
endmodule : host_model
`default_nettype wire

// ===== tb/buffered_dio_board_glue_tb.sv
// Bench of the board glue: random latch data plus corner cases.
// Assumes host_model drives the host bus.
`timescale 1ns/100ps
`default_nettype none
module buffered_dio_board_glue_tb;
   logic clk, nrst, bus_aen, bus_iow_n, bus_ior_n, buf_opt, mapped, rd_oe, casc, tclk;
   logic [2:0] cz;
   time t0;
   logic [9:0] bus_addr, base;
   logic [7:0] wdat, rdat, q, v, irq_line;
   logic [5:0] base_sel;
   logic [2:0] irq_sel;
   logic [47:0] pin_in, pin_out, pin_oe;
   logic [31:0] seed;
   dio_glue_pkg::int_mode_t mode0;
   dio_glue_pkg::int_mode_t mode1;
   int miscompares = 0;
   int n_compared = 0;

   host_model host (.clk(clk), .rdata(rdat), .rdata_oe(rd_oe), .addr(bus_addr), .aen(bus_aen),
      .iow_n(bus_iow_n), .ior_n(bus_ior_n), .wdata(wdat));
   dio_glue dut (.clk(clk), .nrst(nrst), .bus_addr(bus_addr), .bus_aen(bus_aen),
      .bus_iow_n(bus_iow_n), .bus_ior_n(bus_ior_n), .bus_data_in(wdat),
      .bus_data_out(rdat), .bus_data_oe(rd_oe), .base_sel(base_sel), .irq_sel(irq_sel),
      .int_mode0(mode0), .int_mode1(mode1),
      .always_buffer_drive_option(buf_opt), .cascade_en(casc), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .irq_line(irq_line), .timer_clk(tclk),
      .counter_mapped(mapped), .count_zero(cz));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   // Driven lines for a control byte; a set field bit means input
   function automatic logic [23:0] exp_drive(input logic [7:0] c);
      return {{4{~c[3]}}, {4{~c[0]}}, {8{~c[1]}}, {8{~c[4]}}};
   endfunction : exp_drive
   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   task automatic wr(input logic [3:0] o, input logic [7:0] d);
      host.io(1'b1, 1'b0, base + 10'(o), d, q);
   endtask : wr
   task automatic rd(input logic [3:0] o);
      host.io(1'b0, 1'b0, base + 10'(o), 8'h00, q);
   endtask : rd
   // Fresh rising edge on port C bit 3 of both groups, then time to reach the line
   task automatic c3_edge;
      pin_in[19] = 1'b0;
      pin_in[43] = 1'b0;
      repeat (8) @(negedge clk);
      pin_in[19] = 1'b1;
      pin_in[43] = 1'b1;
      repeat (14) @(negedge clk);
   endtask : c3_edge

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Watchdog, far beyond the expected run
   initial begin
      #200000;
      miscompares++;
      results();
   end
   // ******************************************
   // Main sequence
   // ******************************************
   initial begin
      nrst = 1'b0;
      seed = xorshift(32'h0000506D);
      base_sel = seed[5:0];
      irq_sel = seed[10:8];
      base = {base_sel, 4'h0};
      pin_in = 48'h000000000000;
      buf_opt = 1'b0;
      mode0 = dio_glue_pkg::INT_ALWAYS;
      mode1 = dio_glue_pkg::INT_NEVER;
      casc = 1'b0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      chk("pin_oe", pin_oe, 48'h000000000000);
      rd(4'h3);
      chk("ctrl0", q, dio_glue_pkg::CTL_RESET);
      chk("irq", irq_line, 8'h00);
      // Soft tristate keeps lines off until offset E bit 0 is set
      wr(4'h3, 8'h89);
      chk("soft_off", pin_oe, 48'h000000000000);
      wr(4'hE, 8'h01);
      chk("oe0", pin_oe[23:0], exp_drive(8'h89));
      buf_opt = 1'b1;
      wr(4'h7, 8'h81);
      chk("oe1", pin_oe[47:24], exp_drive(8'h81));
      // Random latch data; stray writes outside the window or under aen
      for (int i = 0; i < 8; i++) begin
         seed = xorshift(seed);
         v = seed[7:0];
         wr(4'h4, v);
         host.io(1'b1, 1'b0, base ^ 10'h014, ~v, q);
         host.io(1'b1, 1'b1, base + 10'h004, ~v, q);
         chk("latch", pin_out[31:24], v);
      end
      wr(4'hB, 8'h00);
      c3_edge();
      chk("irq", irq_line, 8'h01 << irq_sel);
      wr(4'hF, 8'h00);
      chk("clr", irq_line, 8'h00);
      c3_edge();
      chk("again", irq_line, 8'h01 << irq_sel);
      rd(4'hB);
      wr(4'hF, 8'h00);
      c3_edge();
      chk("off", irq_line, 8'h00);
      wr(4'hB, 8'h00);
      mode0 = dio_glue_pkg::INT_GATED;
      pin_in[23] = 1'b1;
      c3_edge();
      chk("gate_hi", irq_line, 8'h00);
      pin_in[23] = 1'b0;
      c3_edge();
      chk("gate_lo", irq_line, 8'h01 << irq_sel);
      // Group 1 alone must still reach the shared line
      wr(4'hF, 8'h00);
      mode0 = dio_glue_pkg::INT_NEVER;
      mode1 = dio_glue_pkg::INT_ALWAYS;
      c3_edge();
      chk("grp1", irq_line, 8'h01 << irq_sel);
      wr(4'hD, 8'h00);
      chk("map", mapped, 1'b1);
      // Counters 0 and 1 reload 1 and cascade: counter 1 wraps every 4 us
      wr(4'h0, 8'h01);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h01);
      wr(4'h1, 8'h00);
      chk("g0_shadow", pin_out[7:0], 8'h00);
      casc = 1'b1;
      repeat (2) @(posedge cz[1]);
      t0 = $time;
      @(posedge cz[1]);
      chk("casc", 48'($time - t0), 48'(4 * dio_glue_pkg::TIMER_PERIOD_NS));
      @(negedge clk);
      // Counter clock just fell; all three counters wrapped on that edge
      chk("tick", {tclk, cz}, 4'h7);
      rd(4'hD);
      chk("unmap", mapped, 1'b0);
      results();
   end
endmodule : buffered_dio_board_glue_tb
`default_nettype wire
